// ==== logic/clk_ctrl_pkg.sv ====
// Purpose: Constants and types for the PLL and camera clock control block
// Assumes: Word-wide register port, one system clock
// Notes:   Offsets are byte addresses on the register port
//
// How it works
// [RL1] Camera ratio is bits 7:0 plus one
// [RL2] Camera ratio register resets to 0x00000004
// [RL3] Reserved bits ignore writes, read zero
// [RL4] Software uses only full-word accesses here
// [RL5] Feedback 31:23, input 22:18 dividers read/write
// [RL6] Output divider codes give 1,2,2,4
// [RL7] Stable flag only when enabled and settled
// [RL8] Bypass picks 12 MHz while PLL runs
// [RL9] Enable starts lock; disable selects 12 MHz
// [RL10] Settle wait in slow cycles, reset 0x11
// [RL11] PLL control resets to 0x28080011
// [RL12] Status bits show off, bypass, on
// [RL13] Bit 28 set when PLL change completes
// [RL14] Bit 27 set when main divider change completes
// [RL15] Bit 26 set when source switch completes
// [RL16] Bit 2 stops main clocks during change
// [RL17] Bit 1 selects source switch speed
// [RL18] Bit 0 selects divider change speed
// [RL19] Switch/status register resets to 0x80000000
// [RL20] Effective dividers are fields plus two
// [RL21] Writing one to done flags does nothing
// [RL22] Stable only after full settle count
package clk_ctrl_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [31:0] ADDR_PLL_CONTROL   = 32'h1000_0010;
  localparam logic [31:0] ADDR_PLL_SWITCH    = 32'h1000_0014;
  localparam logic [31:0] ADDR_CAMERA_RATIO  = 32'h1000_007C;

  localparam logic [31:0] RST_PLL_CONTROL    = 32'h2808_0011;
  localparam logic [31:0] RST_PLL_SWITCH     = 32'h8000_0000;
  localparam logic [31:0] RST_CAMERA_RATIO   = 32'h0000_0004;

  // Writable bit masks
  localparam logic [31:0] MASK_PLL_CONTROL   = 32'hFFFF_03FF;
  localparam logic [31:0] MASK_CAMERA_RATIO  = 32'h0000_00FF;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FB_LSB        = 23;
  localparam int IN_LSB        = 18;
  localparam int OD_LSB        = 16;
  localparam int STABLE_BIT    = 10;
  localparam int BYPASS_BIT    = 9;
  localparam int ENABLE_BIT    = 8;
  localparam int OFF_BIT       = 31;
  localparam int BYP_STATE_BIT = 30;
  localparam int ON_BIT        = 29;
  localparam int PDONE_BIT     = 28;
  localparam int DDONE_BIT     = 27;
  localparam int SDONE_BIT     = 26;
  localparam int STOPALL_BIT   = 2;
  localparam int SWSPEED_BIT   = 1;
  localparam int DIVSPEED_BIT  = 0;

  localparam logic [9:0] DIV_OFFSET = 10'h002;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [8:0] feedback_divider;
    logic [4:0] input_divider;
    logic [1:0] output_divider;
    logic       pll_bypass;
    logic       pll_enable;
    logic [7:0] lock_wait_count;
  } pll_cfg_t;

  typedef struct packed {
    logic [9:0] fb_eff;
    logic [9:0] in_eff;
    logic [2:0] out_eff;
  } pll_ratio_t;

  typedef enum logic [2:0] {
    ST_OFF    = 3'h1,
    ST_LOCK   = 3'h2,
    ST_LOCKED = 3'h4
  } pll_state_t;

endpackage

// ==== logic/slow_edge_detect.sv ====
// Purpose: Synchronise the slow timebase clock and pulse on its rise
// Assumes: Slow clock far slower than the system clock
// Notes:   First stage feeds only the second
`timescale 1ns/100ps
module slow_edge_detect (
  // System
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Slow clock level and tick
  input  wire logic slow_i,
  output logic      tick_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      meta_q <= slow_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
      tick_o <= sync_q & ~prev_q;
    end
  end
endmodule

// ==== logic/settle_timer.sv ====
// Purpose: Count slow timebase ticks until the PLL is settled
// Assumes: start_i is a one-cycle pulse
// Notes:   A new start restarts the count
`timescale 1ns/100ps
module settle_timer (
  // System
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic       tick_i,
  input  wire logic [7:0] count_i,
  output logic            done_o
);
  logic [7:0] left_q;
  logic       busy_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      left_q <= 8'h00;
      busy_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        busy_q <= 1'b0;
      end else if (start_i) begin
        left_q <= count_i;
        busy_q <= 1'b1;
      end else if (busy_q && left_q == 8'h00) begin
        busy_q <= 1'b0;
        done_o <= 1'b1;
      end else if (busy_q && tick_i) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule

// ==== logic/pll_clock_control.sv ====
// Purpose: PLL control, PLL switch/status and camera clock ratio registers
// Assumes: Word accesses only; read data one cycle after the read strobe
// Notes:   Analog PLL and main divider sequencer sit outside
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module pll_clock_control
  import clk_ctrl_pkg::*;
(
  // System
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  // Register port
  input  wire logic [31:0] ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  // Timebase and completion events
  input  wire logic        SLOW_TIMEBASE_CLOCK_I,
  input  wire logic        DIVIDER_CHANGE_DONE_I,
  // PLL and clock controls
  output logic             PLL_POWER_O,
  output logic             USE_PLL_SOURCE_O,
  output logic      [9:0]  FEEDBACK_DIVIDE_O,
  output logic      [9:0]  INPUT_DIVIDE_O,
  output logic      [2:0]  OUTPUT_DIVIDE_O,
  output logic      [7:0]  CAMERA_DIVIDE_FIELD_O,
  output logic      [8:0]  CAMERA_RATIO_O,
  output logic             STOP_ALL_ON_DIVIDE_O,
  output logic             SWITCH_SPEED_MODE_O,
  output logic             DIVIDE_SPEED_MODE_O
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] od_ratio(input logic [1:0] code);
    unique case (code)
      2'h0:    od_ratio = 3'h1;
      2'h1:    od_ratio = 3'h2;
      2'h2:    od_ratio = 3'h2;
      default: od_ratio = 3'h4;
    endcase
  endfunction

  function automatic pll_ratio_t ratios(input pll_cfg_t c);
    ratios.fb_eff  = {1'b0, c.feedback_divider} + DIV_OFFSET; // RL20
    ratios.in_eff  = {5'h00, c.input_divider} + DIV_OFFSET;   // RL20
    ratios.out_eff = od_ratio(c.output_divider);              // RL6
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  pll_cfg_t   cfg_q;
  pll_cfg_t   cfg_d;
  logic [7:0] cam_q;
  logic       pdone_q;
  logic       ddone_q;
  logic       sdone_q;
  logic       stop_all_q;
  logic       sw_speed_q;
  logic       div_speed_q;
  pll_state_t state_q;
  logic       src_pll_q;
  logic       tick;
  logic       settle_done;
  logic       settle_start;
  logic       wr_ctl;
  logic       wr_sw;
  logic       wr_cam;
  logic       src_pll_d;
  pll_ratio_t ratio;

  assign wr_ctl = WR_I && (ADDR_I == ADDR_PLL_CONTROL);
  assign wr_sw  = WR_I && (ADDR_I == ADDR_PLL_SWITCH);
  assign wr_cam = WR_I && (ADDR_I == ADDR_CAMERA_RATIO);

  always_comb begin
    cfg_d = cfg_q;
    if (wr_ctl) begin
      cfg_d = pll_cfg_t'({WDATA_I[31:16], WDATA_I[9:0]}); // RL3 RL5
    end
  end

  // ----------------------------------------
  // Settle timing
  // ----------------------------------------
  slow_edge_detect u_edge (
    .clk_i  (CLK_SYS_I),
    .rst_i  (RST_I),
    .slow_i (SLOW_TIMEBASE_CLOCK_I),
    .tick_o (tick)
  );

  // Lock starts on off-to-on and on multiplier change while on
  assign settle_start = wr_ctl && cfg_d.pll_enable &&
    (!cfg_q.pll_enable ||
     cfg_d.feedback_divider != cfg_q.feedback_divider ||
     cfg_d.input_divider != cfg_q.input_divider ||
     cfg_d.output_divider != cfg_q.output_divider); // RL10

  settle_timer u_timer (
    .clk_i   (CLK_SYS_I),
    .rst_i   (RST_I),
    .start_i (settle_start),
    .abort_i (wr_ctl && !cfg_d.pll_enable), // RL9
    .tick_i  (tick),
    .count_i (cfg_d.lock_wait_count),
    .done_o  (settle_done)
  );

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_q <= pll_cfg_t'({RST_PLL_CONTROL[31:16],
                           RST_PLL_CONTROL[9:0]}); // RL11
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      cam_q <= RST_CAMERA_RATIO[7:0]; // RL2
    end else if (wr_cam) begin
      cam_q <= WDATA_I[7:0]; // RL1 RL3
    end
  end

  // ----------------------------------------
  // PLL state machine
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= ST_OFF;
    end else if (wr_ctl && !cfg_d.pll_enable) begin
      state_q <= ST_OFF; // RL9
    end else if (settle_start) begin
      state_q <= ST_LOCK; // RL9
    end else begin
      unique case (state_q)
        ST_OFF:    state_q <= ST_OFF;
        ST_LOCK:   if (settle_done) begin
          state_q <= ST_LOCKED; // RL22
        end
        ST_LOCKED: state_q <= ST_LOCKED;
        default:   state_q <= ST_OFF;
      endcase
    end
  end

  // Source follows PLL only when locked and not bypassed
  assign src_pll_d = (state_q == ST_LOCKED) && cfg_q.pll_enable &&
                     !cfg_q.pll_bypass; // RL8 RL9

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      src_pll_q <= 1'b0;
    end else begin
      src_pll_q <= src_pll_d;
    end
  end

  // ----------------------------------------
  // Completion flags: set beats clear
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      pdone_q <= RST_PLL_SWITCH[PDONE_BIT];
      ddone_q <= RST_PLL_SWITCH[DDONE_BIT];
      sdone_q <= RST_PLL_SWITCH[SDONE_BIT];
    end else begin
      if (state_q == ST_LOCK && settle_done) begin
        pdone_q <= 1'b1; // RL13
      end else if (wr_sw && !WDATA_I[PDONE_BIT]) begin
        pdone_q <= 1'b0; // RL21
      end
      if (DIVIDER_CHANGE_DONE_I) begin
        ddone_q <= 1'b1; // RL14
      end else if (wr_sw && !WDATA_I[DDONE_BIT]) begin
        ddone_q <= 1'b0; // RL21
      end
      if (src_pll_d != src_pll_q) begin
        sdone_q <= 1'b1; // RL15
      end else if (wr_sw && !WDATA_I[SDONE_BIT]) begin
        sdone_q <= 1'b0; // RL21
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      stop_all_q  <= RST_PLL_SWITCH[STOPALL_BIT]; // RL19
      sw_speed_q  <= RST_PLL_SWITCH[SWSPEED_BIT];
      div_speed_q <= RST_PLL_SWITCH[DIVSPEED_BIT];
    end else if (wr_sw) begin
      stop_all_q  <= WDATA_I[STOPALL_BIT];  // RL16
      sw_speed_q  <= WDATA_I[SWSPEED_BIT];  // RL17
      div_speed_q <= WDATA_I[DIVSPEED_BIT]; // RL18
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 32'h0000_0000;
    end else begin
      RDATA_O <= 32'h0000_0000; // RL3
      if (RD_I) begin
        unique case (ADDR_I)
          ADDR_PLL_CONTROL: begin
            RDATA_O[31:16] <= cfg_q[25:10];
            RDATA_O[9:0]   <= cfg_q[9:0];
            RDATA_O[STABLE_BIT] <= (state_q == ST_LOCKED) &&
                                   cfg_q.pll_enable; // RL7
          end
          ADDR_PLL_SWITCH: begin
            RDATA_O[OFF_BIT]       <= (state_q == ST_OFF); // RL12
            RDATA_O[BYP_STATE_BIT] <= (state_q == ST_LOCKED) &&
                                      cfg_q.pll_bypass; // RL12
            RDATA_O[ON_BIT]        <= (state_q == ST_LOCKED) &&
                                      !cfg_q.pll_bypass; // RL12
            RDATA_O[PDONE_BIT]     <= pdone_q;
            RDATA_O[DDONE_BIT]     <= ddone_q;
            RDATA_O[SDONE_BIT]     <= sdone_q;
            RDATA_O[STOPALL_BIT]   <= stop_all_q;
            RDATA_O[SWSPEED_BIT]   <= sw_speed_q;
            RDATA_O[DIVSPEED_BIT]  <= div_speed_q;
          end
          ADDR_CAMERA_RATIO: RDATA_O[7:0] <= cam_q;
          default:           RDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  assign ratio = ratios(cfg_q);

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      PLL_POWER_O           <= 1'b0;
      USE_PLL_SOURCE_O      <= 1'b0;
      FEEDBACK_DIVIDE_O     <= 10'h000;
      INPUT_DIVIDE_O        <= 10'h000;
      OUTPUT_DIVIDE_O       <= 3'h0;
      CAMERA_DIVIDE_FIELD_O <= 8'h00;
      CAMERA_RATIO_O        <= 9'h000;
      STOP_ALL_ON_DIVIDE_O  <= 1'b0;
      SWITCH_SPEED_MODE_O   <= 1'b0;
      DIVIDE_SPEED_MODE_O   <= 1'b0;
    end else begin
      PLL_POWER_O           <= cfg_q.pll_enable; // RL9
      USE_PLL_SOURCE_O      <= src_pll_q;
      FEEDBACK_DIVIDE_O     <= ratio.fb_eff;
      INPUT_DIVIDE_O        <= ratio.in_eff;
      OUTPUT_DIVIDE_O       <= ratio.out_eff;
      CAMERA_DIVIDE_FIELD_O <= cam_q;
      CAMERA_RATIO_O        <= {1'b0, cam_q} + 9'h001; // RL1
      STOP_ALL_ON_DIVIDE_O  <= stop_all_q;
      SWITCH_SPEED_MODE_O   <= sw_speed_q;
      DIVIDE_SPEED_MODE_O   <= div_speed_q;
    end
  end

endmodule

// ==== bench/pll_clock_control_checker.sv ====
// Purpose: Port checks for the PLL and camera clock control block
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound from the testbench top file
`timescale 1ns/100ps
module pll_clock_control_checker
  import clk_ctrl_pkg::*;
(
  // System
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  // Register port
  input  wire logic [31:0] ADDR_I,
  input  wire logic        RD_I,
  input  wire logic [31:0] RDATA_O,
  // Controls
  input  wire logic        PLL_POWER_O,
  input  wire logic        USE_PLL_SOURCE_O,
  input  wire logic [9:0]  FEEDBACK_DIVIDE_O,
  input  wire logic [9:0]  INPUT_DIVIDE_O,
  input  wire logic [2:0]  OUTPUT_DIVIDE_O,
  input  wire logic [7:0]  CAMERA_DIVIDE_FIELD_O,
  input  wire logic [8:0]  CAMERA_RATIO_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);

  property p_read_idle;
    !$past(RD_I) |-> RDATA_O == 32'h0;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not zero outside read slot");
  property p_cam_resv;
    RD_I && ADDR_I == ADDR_CAMERA_RATIO |=> RDATA_O[31:8] == 24'h0;
  endproperty
  a_cam_resv: assert property (p_cam_resv)
    else $error("camera reserved bits not zero");
  property p_ctl_resv;
    RD_I && ADDR_I == ADDR_PLL_CONTROL |=> RDATA_O[15:11] == 5'h0;
  endproperty
  a_ctl_resv: assert property (p_ctl_resv)
    else $error("control reserved bits not zero");
  property p_sw_resv;
    RD_I && ADDR_I == ADDR_PLL_SWITCH |=> RDATA_O[25:3] == 23'h0;
  endproperty
  a_sw_resv: assert property (p_sw_resv)
    else $error("status reserved bits not zero");
  property p_use_rise;
    $rose(USE_PLL_SOURCE_O) |-> PLL_POWER_O;
  endproperty
  a_use_rise: assert property (p_use_rise)
    else $error("PLL source chosen while PLL unpowered");
  property p_od_map;
    !$past(RST_I) |-> OUTPUT_DIVIDE_O inside {3'h1, 3'h2, 3'h4};
  endproperty
  a_od_map: assert property (p_od_map)
    else $error("output divide value illegal");
  property p_div_range;
    !$past(RST_I) |-> FEEDBACK_DIVIDE_O inside {[10'h002:10'h201]}
      && INPUT_DIVIDE_O inside {[10'h002:10'h021]};
  endproperty
  a_div_range: assert property (p_div_range)
    else $error("effective divider out of range");
  property p_cam_ratio;
    !$past(RST_I) |->
      CAMERA_RATIO_O == {1'b0, CAMERA_DIVIDE_FIELD_O} + 9'h001;
  endproperty
  a_cam_ratio: assert property (p_cam_ratio)
    else $error("camera ratio not field plus one");
endmodule

// ==== bench/pll_clock_control_test.sv ====
// Purpose: Register-level test of the PLL and camera clock control block
// Assumes: Slow timebase toggles every 8 system cycles
// Notes:   Lock tests use a settle count of 2 slow ticks
`timescale 1ns/100ps
module pll_clock_control_test;
  import clk_ctrl_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        div_done = 1'b0;
  logic [3:0]  slow_cnt = 4'h0;
  logic [31:0] rdata, got, v;
  logic        power, use_pll;
  logic [9:0]  fb_div, in_div;
  logic [2:0]  out_div, modes;
  logic [7:0]  cam_field;
  logic [8:0]  cam_ratio;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          t0;

  always #4 clk = ~clk;
  always @(posedge clk) begin
    slow_cnt <= slow_cnt + 4'h1;
    cyc <= cyc + 1;
  end

  pll_clock_control u_pll_clock_control (
    .CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SLOW_TIMEBASE_CLOCK_I(slow_cnt[3]), .DIVIDER_CHANGE_DONE_I(div_done),
    .PLL_POWER_O(power), .USE_PLL_SOURCE_O(use_pll),
    .FEEDBACK_DIVIDE_O(fb_div), .INPUT_DIVIDE_O(in_div),
    .OUTPUT_DIVIDE_O(out_div), .CAMERA_DIVIDE_FIELD_O(cam_field),
    .CAMERA_RATIO_O(cam_ratio), .STOP_ALL_ON_DIVIDE_O(modes[2]),
    .SWITCH_SPEED_MODE_O(modes[1]), .DIVIDE_SPEED_MODE_O(modes[0])
  );

  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wreg(input logic [31:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rc(input string n, input logic [31:0] a, m, e);
    rreg(a, got);
    chk(n, e, got & m);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc("ctl", ADDR_PLL_CONTROL, '1, 32'h2808_0011);
    rc("sw", ADDR_PLL_SWITCH, '1, 32'h8000_0000);
    rc("cam", ADDR_CAMERA_RATIO, '1, 32'h0000_0004);
    chk("fb", 32'h52, {22'h0, fb_div});
    chk("in", 32'h4, {22'h0, in_div});
    chk("ratio", 32'h5, {23'h0, cam_ratio});
    $display("test reset done");
    wreg(ADDR_CAMERA_RATIO, '1);
    rc("cam", ADDR_CAMERA_RATIO, '1, 32'hFF);
    chk("ratio", 32'h100, {23'h0, cam_ratio});
    wreg(32'h1000_0018, '1);
    rc("unmapped", 32'h1000_0018, '1, 32'h0);
    $display("test camera done");
    for (int od = 0; od < 4; od++) begin
      v = {9'h1FF, 5'h1F, od[1:0], 5'h1F, 3'h6, 8'h00};
      wreg(ADDR_PLL_CONTROL, v);
      rc("ctl", ADDR_PLL_CONTROL, '1, v & 32'hFFFF_03FF);
      chk("od", (od == 3) ? 4 : (od == 0) ? 1 : 2, {29'h0, out_div});
      chk("fb in", 32'h0201_0021, {6'h0, fb_div, 6'h0, in_div});
      chk("src", 32'h0, {30'h0, power, use_pll});
      rc("sw", ADDR_PLL_SWITCH, 32'hE000_0000, 32'h8000_0000);
    end
    $display("test fields done");
    wreg(ADDR_PLL_SWITCH, 32'h0);
    wreg(ADDR_PLL_CONTROL, 32'h2808_0102);
    t0 = cyc;
    rc("early", ADDR_PLL_CONTROL, 32'h400, 32'h0);
    got = 32'h0;
    for (int i = 0; i < 100 && got[10] !== 1'b1; i++) begin
      rreg(ADDR_PLL_CONTROL, got);
    end
    chk("stable", 32'h2808_0502, got);
    chk("wait", 32'h1, {31'h0, (cyc - t0) >= 16});
    rc("sw", ADDR_PLL_SWITCH, '1, 32'h3400_0000);
    chk("src", 32'h3, {30'h0, power, use_pll});
    $display("test lock done");
    wreg(ADDR_PLL_SWITCH, 32'h1C00_0007);
    rc("sw", ADDR_PLL_SWITCH, '1, 32'h3400_0007);
    chk("modes", 32'h7, {29'h0, modes});
    wreg(ADDR_PLL_SWITCH, 32'h0);
    rc("sw", ADDR_PLL_SWITCH, '1, 32'h2000_0000);
    chk("modes", 32'h0, {29'h0, modes});
    @(posedge clk);
    div_done <= 1'b1;
    @(posedge clk);
    div_done <= 1'b0;
    rc("sw", ADDR_PLL_SWITCH, '1, 32'h2800_0000);
    $display("test flags done");
    wreg(ADDR_PLL_CONTROL, 32'h2808_0302);
    rc("sw", ADDR_PLL_SWITCH, 32'hCC00_0000, 32'h4C00_0000);
    rc("ctl", ADDR_PLL_CONTROL, '1, 32'h2808_0702);
    chk("src", 32'h2, {30'h0, power, use_pll});
    wreg(ADDR_PLL_SWITCH, 32'h0);
    wreg(ADDR_PLL_CONTROL, 32'h2808_0102);
    rc("sw", ADDR_PLL_SWITCH, 32'hEC00_0000, 32'h2400_0000);
    chk("src", 32'h3, {30'h0, power, use_pll});
    wreg(ADDR_PLL_SWITCH, 32'h0);
    wreg(ADDR_PLL_CONTROL, 32'h2808_0202);
    rc("sw", ADDR_PLL_SWITCH, 32'hE400_0000, 32'h8400_0000);
    rc("ctl", ADDR_PLL_CONTROL, '1, 32'h2808_0202);
    chk("src", 32'h0, {30'h0, power, use_pll});
    $display("test bypass done");
    close_out();
  end
endmodule

bind pll_clock_control pll_clock_control_checker u_pll_clock_control_checker (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .PLL_POWER_O(PLL_POWER_O),
  .USE_PLL_SOURCE_O(USE_PLL_SOURCE_O), .FEEDBACK_DIVIDE_O(FEEDBACK_DIVIDE_O),
  .INPUT_DIVIDE_O(INPUT_DIVIDE_O), .OUTPUT_DIVIDE_O(OUTPUT_DIVIDE_O),
  .CAMERA_DIVIDE_FIELD_O(CAMERA_DIVIDE_FIELD_O),
  .CAMERA_RATIO_O(CAMERA_RATIO_O)
);
